/* include/rre_pkg.sv */
// constants and types shared by the register reference execute unit
package rre_pkg;
    // datapath width and constant operands
    localparam int unsigned RRE_W = 16;
    localparam logic [15:0] RRE_ONES = 16'hFFFF;
    localparam logic [15:0] RRE_ONE = 16'h0001;
    localparam int unsigned RRE_SIGN = 15;
    // instruction field positions
    localparam int unsigned FMT_HI = 15;
    localparam int unsigned FMT_LO = 12;
    localparam int unsigned OPC_HI = 11;
    localparam int unsigned OPC_LO = 8;
    localparam int unsigned MOD_HI = 7;
    localparam int unsigned SKC_HI = 7;
    localparam int unsigned SKC_LO = 4;
    localparam int unsigned SKN_HI = 3;
    localparam int unsigned IR_LP = 7;
    localparam int unsigned IR_XR = 6;
    localparam int unsigned IR_OP1 = 5;
    localparam int unsigned IR_OP2_HI = 4;
    localparam int unsigned IR_OP2_LO = 3;
    localparam int unsigned IR_DA = 2;
    localparam int unsigned IR_DQ = 1;
    localparam int unsigned IR_DM = 0;
    // format and register op codes
    localparam logic [3:0] FMT_REGREF = 4'h0;
    localparam logic [3:0] OP_STOP = 4'h0;
    localparam logic [3:0] OP_SKIP = 4'h1;
    localparam logic [3:0] OP_EIN = 4'h4;
    localparam logic [3:0] OP_IIN = 4'h5;
    localparam logic [3:0] OP_SPB = 4'h6;
    localparam logic [3:0] OP_CPB = 4'h7;
    localparam logic [3:0] OP_IREG = 4'h8;
    localparam logic [3:0] OP_INQ = 4'hD;
    localparam logic [3:0] OP_EXI = 4'hE;
    localparam logic [7:0] MOD_ZERO = 8'h00;
    // skip condition codes
    localparam logic [3:0] SK_PAR = 4'hC;
    localparam logic [3:0] SK_OVF = 4'hA;
    localparam logic [3:0] SK_PF = 4'hE;
    // register map, byte addresses
    localparam int unsigned AXI_AW = 4;
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STAT = 4'h4;
    // function control bits
    localparam int unsigned CTL_W = 4;
    localparam int unsigned CTL_PROT = 0;
    localparam int unsigned CTL_STOP = 1;
    localparam int unsigned CTL_SSKIP = 2;
    localparam int unsigned CTL_PFSEL = 3;
    localparam logic [3:0] CTL_RST = 4'h0;
    // status bits
    localparam int unsigned ST_OVF = 0;
    localparam int unsigned ST_PF = 1;
    localparam int unsigned ST_PAR = 2;
    localparam int unsigned ST_INTON = 3;
    localparam int unsigned ST_HALT = 4;
    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    // write channel states, one-hot
    typedef enum logic [1:0] {
        WR_IDLE = 2'b01,
        WR_RESP = 2'b10
    } rre_wr_st_type;
endpackage

/* hdl/rre_ones_adder.sv */
// sixteen bit one's complement adder with end-around carry
`timescale 1ns/1ps
`default_nettype none
module rre_ones_adder
    import rre_pkg::*;
(
    // operands
    input wire logic [15:0] a_i,
    input wire logic [15:0] b_i,
    // result
    output logic [15:0] sum_o,
    output logic ovf_o
);
    logic [16:0] raw; // binary sum with carry out
    logic [16:0] wrapped; // after end-around carry

    // carry out folds back into bit 0, which is what makes it one's complement
    always_comb begin
        raw = {1'b0, a_i} + {1'b0, b_i};
        wrapped = {1'b0, raw[15:0]} + {16'h0000, raw[16]};
        sum_o = wrapped[15:0];
        // like signs in, other sign out: magnitude left the register
        ovf_o = (a_i[RRE_SIGN] == b_i[RRE_SIGN]) && (sum_o[RRE_SIGN] != a_i[RRE_SIGN]);
    end
endmodule // rre_ones_adder
`default_nettype wire

/* hdl/rre_exec.sv */
// register reference instruction execute unit with its control registers
// How it works
// - increase Q by sign-extended modifier, overflow
// - protect on: unprotected protected-class becomes stop
// - enable activates interrupts; need active and mask
// - inhibit deactivates interrupt recognition
// - set protect bit at address Q
// - clear protect bit at address Q
// - exit selects level, jumps, re-enables interrupts
// - unprotected interregister to M stops, faults
// - operand one: ones or A by bit5
// - operand two: ones, M, Q, Q or M
// - function bits: sum, and, xor
// - both function bits: complement of and
// - skip adds count plus one, else P+1
// - codes 0-7 test A then Q
// - codes 8-F test switch, overflow, parity, fault
// - overflow skip clears overflow
// - parity skip clears parity signal and indicator
// - fault on three protect violations
// - fault skips clear; never set when disabled
// - protect switch is a function control bit
// - zero top nibble, opcode, signed modifier
// - selective stop halts only with stop switch
// - one's complement adds, sticky overflow
`timescale 1ns/1ps
`default_nettype none
module rre_exec
    import rre_pkg::*;
(
    // clock, reset, enable
    input wire logic MCLK_I,
    input wire logic RST_B_I,
    input wire logic CE_I,
    // instruction and operand registers
    input wire logic EXEC_I,
    input wire logic [15:0] INSTR_I,
    input wire logic INSTR_PROT_I,
    input wire logic INT_ENTRY_I,
    input wire logic [15:0] P_I,
    input wire logic [15:0] A_I,
    input wire logic [15:0] Q_I,
    input wire logic [15:0] M_I,
    input wire logic [15:0] RET_ADDR_I,
    // storage and interrupt events
    input wire logic PROT_VIOL_I,
    input wire logic PARITY_ERR_I,
    input wire logic [15:0] IRQ_REQ_I,
    input wire logic [15:0] IRQ_MASK_I,
    // execution results
    output logic DONE_O,
    output logic [15:0] NEXT_P_O,
    output logic [15:0] A_O,
    output logic [15:0] Q_O,
    output logic [15:0] M_O,
    output logic A_WE_O,
    output logic Q_WE_O,
    output logic M_WE_O,
    output logic HALT_O,
    output logic PROT_SET_O,
    output logic PROT_CLR_O,
    output logic [15:0] PROT_ADDR_O,
    output logic EXIT_O,
    output logic [7:0] EXIT_LEVEL_O,
    output logic PARITY_CLR_O,
    output logic PF_IRQ_O,
    output logic INT_TAKE_O,
    // axi4-lite slave
    input wire logic [3:0] S_AXI_AWADDR_I,
    input wire logic S_AXI_AWVALID_I,
    output logic S_AXI_AWREADY_O,
    input wire logic [31:0] S_AXI_WDATA_I,
    input wire logic [3:0] S_AXI_WSTRB_I,
    input wire logic S_AXI_WVALID_I,
    output logic S_AXI_WREADY_O,
    output logic [1:0] S_AXI_BRESP_O,
    output logic S_AXI_BVALID_O,
    input wire logic S_AXI_BREADY_I,
    input wire logic [3:0] S_AXI_ARADDR_I,
    input wire logic S_AXI_ARVALID_I,
    output logic S_AXI_ARREADY_O,
    output logic [31:0] S_AXI_RDATA_O,
    output logic [1:0] S_AXI_RRESP_O,
    output logic S_AXI_RVALID_O,
    input wire logic S_AXI_RREADY_I
);
    ////////////////////////////////////////////////////////////////////////////////
    // decode
    logic [3:0] fmt; // upper nibble, zero for this class
    logic [3:0] opc; // register op code
    logic [7:0] modf; // signed modifier
    logic [15:0] sext; // modifier sign-extended
    logic go; // an instruction executes this cycle
    logic [CTL_W-1:0] ctl_q, ctl_d; // function control bits
    logic ovf_q, ovf_d; // sticky overflow
    logic pf_q, pf_d; // program protect fault
    logic par_q, par_d; // storage parity indicator
    logic inton_q, inton_d; // interrupt system active
    logic halt_q, halt_d; // sticky halted flag
    logic unprot_q, unprot_d; // last instruction was unprotected

    // sign extension of the modifier serves increase-Q; exit takes the raw modifier
    function automatic logic [15:0] sign_ext(input logic [7:0] v);
        sign_ext = {{8{v[MOD_HI]}}, v};
    endfunction

    always_comb begin
        fmt = INSTR_I[FMT_HI:FMT_LO];
        opc = INSTR_I[OPC_HI:OPC_LO];
        modf = INSTR_I[MOD_HI:0];
        sext = sign_ext(modf);
        go = CE_I && EXEC_I && (fmt == FMT_REGREF);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // operand selection and adder
    logic [15:0] op1, op2, add_a, add_b, add_sum, ir_res;
    logic add_ovf;
    logic is_inq, is_ir, is_skip, is_ein, is_iin, is_spb, is_cpb, is_exi, is_stop;
    logic lp, xr;

    always_comb begin
        is_inq = go && (opc == OP_INQ);
        is_ir = go && (opc == OP_IREG);
        is_skip = go && (opc == OP_SKIP);
        is_ein = go && (opc == OP_EIN) && (modf == MOD_ZERO);
        is_iin = go && (opc == OP_IIN) && (modf == MOD_ZERO);
        is_spb = go && (opc == OP_SPB) && (modf == MOD_ZERO);
        is_cpb = go && (opc == OP_CPB) && (modf == MOD_ZERO);
        is_exi = go && (opc == OP_EXI);
        is_stop = go && (opc == OP_STOP) && (modf == MOD_ZERO);
        lp = INSTR_I[IR_LP];
        xr = INSTR_I[IR_XR];
        op1 = INSTR_I[IR_OP1] ? A_I : RRE_ONES;
        case (INSTR_I[IR_OP2_HI:IR_OP2_LO])
            2'b00: op2 = RRE_ONES;
            2'b01: op2 = M_I;
            2'b10: op2 = Q_I;
            default: op2 = Q_I | M_I;
        endcase
        // one adder is shared, the two users never run together
        add_a = is_inq ? Q_I : op1;
        add_b = is_inq ? sext : op2;
        case ({lp, xr})
            2'b00: ir_res = add_sum;
            2'b10: ir_res = op1 & op2;
            2'b01: ir_res = op1 ^ op2;
            default: ir_res = ~(op1 & op2);
        endcase
    end

    rre_ones_adder u_add (
        .a_i(add_a),
        .b_i(add_b),
        .sum_o(add_sum),
        .ovf_o(add_ovf)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // protection and skip conditions
    logic prot_sw, prot_class, illegal, sel_stop, pf_set, skip_cond, skip_ovf;
    logic [3:0] skc;

    always_comb begin
        prot_sw = ctl_q[CTL_PROT];
        skc = INSTR_I[SKC_HI:SKC_LO];
        prot_class = is_ein || is_iin || is_spb || is_cpb || is_exi || (is_ir && INSTR_I[IR_DM]);
        illegal = prot_sw && !INSTR_PROT_I && prot_class;
        sel_stop = is_stop || illegal;
        // violations only count while protection is switched on
        pf_set = prot_sw && (illegal || PROT_VIOL_I
                 || (go && INSTR_PROT_I && unprot_q && !INT_ENTRY_I));
        case (skc)
            4'h0: skip_cond = (A_I == 16'h0000);
            4'h1: skip_cond = (A_I != 16'h0000);
            4'h2: skip_cond = !A_I[RRE_SIGN];
            4'h3: skip_cond = A_I[RRE_SIGN];
            4'h4: skip_cond = (Q_I == 16'h0000);
            4'h5: skip_cond = (Q_I != 16'h0000);
            4'h6: skip_cond = !Q_I[RRE_SIGN];
            4'h7: skip_cond = Q_I[RRE_SIGN];
            4'h8: skip_cond = ctl_q[CTL_SSKIP];
            4'h9: skip_cond = !ctl_q[CTL_SSKIP];
            4'hA: skip_cond = ovf_q;
            4'hB: skip_cond = !ovf_q;
            4'hC: skip_cond = par_q;
            4'hD: skip_cond = !par_q;
            4'hE: skip_cond = pf_q;
            default: skip_cond = !pf_q;
        endcase
        skip_ovf = is_skip && (skc == SK_OVF);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // result next values
    logic done_d, a_we_d, q_we_d, m_we_d, halt_p_d, pset_d, pclr_d, exit_d, parclr_d, pfirq_d, take_d;
    logic [15:0] np_d, a_d, q_d, m_d;

    always_comb begin
        done_d = go;
        np_d = P_I + RRE_ONE;
        a_d = ir_res;
        q_d = ir_res;
        m_d = ir_res;
        a_we_d = 1'b0;
        q_we_d = 1'b0;
        m_we_d = 1'b0;
        pset_d = 1'b0;
        pclr_d = 1'b0;
        exit_d = 1'b0;
        halt_p_d = sel_stop && ctl_q[CTL_STOP];
        parclr_d = is_skip && (skc == SK_PAR);
        pfirq_d = pf_set && ctl_q[CTL_PFSEL];
        take_d = inton_q && ((IRQ_REQ_I & IRQ_MASK_I) != 16'h0000);
        if (!sel_stop) begin
            if (is_inq) begin
                q_d = add_sum;
                q_we_d = 1'b1;
            end
            if (is_ir) begin
                a_we_d = INSTR_I[IR_DA];
                q_we_d = INSTR_I[IR_DQ];
                m_we_d = INSTR_I[IR_DM];
            end
            pset_d = is_spb;
            pclr_d = is_cpb;
            if (is_exi) begin
                exit_d = 1'b1;
                np_d = RET_ADDR_I;
            end
            if (is_skip && skip_cond) begin
                np_d = P_I + {12'h000, INSTR_I[SKN_HI:0]} + RRE_ONE;
            end
        end
    end

    // results register on every enabled clock; DONE_O flags an accepted instruction
    always_ff @(posedge MCLK_I) begin
        if (!RST_B_I) begin
            DONE_O <= 1'b0;
            NEXT_P_O <= 16'h0000;
            A_O <= 16'h0000;
            Q_O <= 16'h0000;
            M_O <= 16'h0000;
            A_WE_O <= 1'b0;
            Q_WE_O <= 1'b0;
            M_WE_O <= 1'b0;
            HALT_O <= 1'b0;
            PROT_SET_O <= 1'b0;
            PROT_CLR_O <= 1'b0;
            PROT_ADDR_O <= 16'h0000;
            EXIT_O <= 1'b0;
            EXIT_LEVEL_O <= 8'h00;
            PARITY_CLR_O <= 1'b0;
            PF_IRQ_O <= 1'b0;
            INT_TAKE_O <= 1'b0;
        end else if (CE_I) begin
            DONE_O <= done_d;
            NEXT_P_O <= np_d;
            A_O <= a_d;
            Q_O <= q_d;
            M_O <= m_d;
            A_WE_O <= a_we_d;
            Q_WE_O <= q_we_d;
            M_WE_O <= m_we_d;
            HALT_O <= halt_p_d;
            PROT_SET_O <= pset_d;
            PROT_CLR_O <= pclr_d;
            PROT_ADDR_O <= Q_I;
            EXIT_O <= exit_d;
            EXIT_LEVEL_O <= modf;
            PARITY_CLR_O <= parclr_d;
            PF_IRQ_O <= pfirq_d;
            INT_TAKE_O <= take_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // sticky state; a set arriving with its clear wins
    logic halt_w1c; // software clears the halted flag

    always_comb begin
        ovf_d = ovf_q;
        if (skip_ovf) begin
            ovf_d = 1'b0;
        end
        if ((is_inq || (is_ir && !sel_stop && !lp && !xr)) && add_ovf) begin
            ovf_d = 1'b1;
        end
        pf_d = pf_q;
        if (is_skip && (skc[3:1] == SK_PF[3:1])) begin
            pf_d = 1'b0;
        end
        if (pf_set) begin
            pf_d = 1'b1;
        end
        par_d = parclr_d ? 1'b0 : par_q;
        if (PARITY_ERR_I) begin
            par_d = 1'b1;
        end
        inton_d = inton_q;
        if (!sel_stop && (is_ein || is_exi)) begin
            inton_d = 1'b1;
        end
        if (!sel_stop && is_iin) begin
            inton_d = 1'b0;
        end
        halt_d = halt_w1c ? 1'b0 : halt_q;
        if (halt_p_d) begin
            halt_d = 1'b1;
        end
        unprot_d = go ? !INSTR_PROT_I : unprot_q;
    end

    always_ff @(posedge MCLK_I) begin
        if (!RST_B_I) begin
            ovf_q <= 1'b0;
            pf_q <= 1'b0;
            par_q <= 1'b0;
            inton_q <= 1'b0;
            halt_q <= 1'b0;
            unprot_q <= 1'b0;
        end else if (CE_I) begin
            ovf_q <= ovf_d;
            pf_q <= pf_d;
            par_q <= par_d;
            inton_q <= inton_d;
            halt_q <= halt_d;
            unprot_q <= unprot_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // axi4-lite slave; address and data are latched in either order
    rre_wr_st_type wst_q, wst_d;
    logic aw_got_q, aw_got_d, w_got_q, w_got_d, rv_q, rv_d;
    logic [3:0] awa_q, awa_d;
    logic [31:0] wd_q, wd_d, rd_q, rd_d;
    logic [3:0] ws_q, ws_d;
    logic [1:0] br_q, br_d, rr_q, rr_d;
    logic do_wr;

    always_comb begin
        wst_d = wst_q;
        aw_got_d = aw_got_q;
        w_got_d = w_got_q;
        awa_d = awa_q;
        wd_d = wd_q;
        ws_d = ws_q;
        br_d = br_q;
        ctl_d = ctl_q;
        halt_w1c = 1'b0;
        do_wr = 1'b0;
        S_AXI_AWREADY_O = (wst_q == WR_IDLE) && !aw_got_q;
        S_AXI_WREADY_O = (wst_q == WR_IDLE) && !w_got_q;
        case (wst_q)
            WR_IDLE: begin
                if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
                    aw_got_d = 1'b1;
                    awa_d = S_AXI_AWADDR_I;
                end
                if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
                    w_got_d = 1'b1;
                    wd_d = S_AXI_WDATA_I;
                    ws_d = S_AXI_WSTRB_I;
                end
                do_wr = aw_got_q && w_got_q;
                if (do_wr) begin
                    aw_got_d = 1'b0;
                    w_got_d = 1'b0;
                    wst_d = WR_RESP;
                    br_d = RESP_OKAY;
                    if (awa_q == REG_CTRL) begin
                        if (ws_q[0]) begin
                            ctl_d = wd_q[CTL_W-1:0];
                        end
                    end else if (awa_q == REG_STAT) begin
                        halt_w1c = ws_q[0] && wd_q[ST_HALT];
                    end else begin
                        br_d = RESP_DECERR;
                    end
                end
            end
            WR_RESP: begin
                if (S_AXI_BREADY_I) begin
                    wst_d = WR_IDLE;
                end
            end
            default: wst_d = WR_IDLE;
        endcase
        // read side: one outstanding read, answered the cycle after acceptance
        rv_d = rv_q;
        rd_d = rd_q;
        rr_d = rr_q;
        S_AXI_ARREADY_O = !rv_q;
        if (rv_q && S_AXI_RREADY_I) begin
            rv_d = 1'b0;
        end
        if (S_AXI_ARVALID_I && !rv_q) begin
            rv_d = 1'b1;
            rr_d = RESP_OKAY;
            rd_d = 32'h00000000;
            if (S_AXI_ARADDR_I == REG_CTRL) begin
                rd_d[CTL_W-1:0] = ctl_q;
            end else if (S_AXI_ARADDR_I == REG_STAT) begin
                rd_d[ST_OVF] = ovf_q;
                rd_d[ST_PF] = pf_q;
                rd_d[ST_PAR] = par_q;
                rd_d[ST_INTON] = inton_q;
                rd_d[ST_HALT] = halt_q;
            end else begin
                rr_d = RESP_DECERR;
            end
        end
        S_AXI_BVALID_O = (wst_q == WR_RESP);
        S_AXI_BRESP_O = br_q;
        S_AXI_RVALID_O = rv_q;
        S_AXI_RDATA_O = rd_q;
        S_AXI_RRESP_O = rr_q;
    end

    always_ff @(posedge MCLK_I) begin
        if (!RST_B_I) begin
            wst_q <= WR_IDLE;
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            awa_q <= 4'h0;
            wd_q <= 32'h00000000;
            ws_q <= 4'h0;
            br_q <= RESP_OKAY;
            ctl_q <= CTL_RST;
            rv_q <= 1'b0;
            rd_q <= 32'h00000000;
            rr_q <= RESP_OKAY;
        end else if (CE_I) begin
            wst_q <= wst_d;
            aw_got_q <= aw_got_d;
            w_got_q <= w_got_d;
            awa_q <= awa_d;
            wd_q <= wd_d;
            ws_q <= ws_d;
            br_q <= br_d;
            ctl_q <= ctl_d;
            rv_q <= rv_d;
            rd_q <= rd_d;
            rr_q <= rr_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (!RST_B_I);

    property p_inq_write;
        is_inq && !sel_stop |=> Q_WE_O && !A_WE_O && (Q_O == $past(add_sum));
    endproperty
    a_inq_write: assert property (p_inq_write) else $error("increase q result wrong");
    property p_illegal_stop;
        illegal |=> DONE_O && !A_WE_O && !Q_WE_O && !M_WE_O && !PROT_SET_O && !EXIT_O
            && (NEXT_P_O == $past(P_I) + RRE_ONE);
    endproperty
    a_illegal_stop: assert property (p_illegal_stop) else $error("illegal instruction had effect");
    property p_take;
        INT_TAKE_O |-> $past(inton_q) && ($past(IRQ_REQ_I & IRQ_MASK_I) != 16'h0000);
    endproperty
    a_take: assert property (p_take) else $error("interrupt taken while inactive or masked");
    property p_inhibit;
        is_iin && !illegal |=> !inton_q ##1 !INT_TAKE_O;
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("interrupt system still active");
    property p_spb;
        is_spb && !illegal |=> PROT_SET_O && !PROT_CLR_O && (PROT_ADDR_O == $past(Q_I));
    endproperty
    a_spb: assert property (p_spb) else $error("protect set wrong");
    property p_xor_am;
        is_ir && !illegal && (INSTR_I[7:3] == 5'b01101) && INSTR_I[IR_DA]
            |=> A_WE_O && (A_O == ($past(A_I) ^ $past(M_I)));
    endproperty
    a_xor_am: assert property (p_xor_am) else $error("exclusive or result wrong");
    property p_nand;
        is_ir && !illegal && lp && xr |=> (A_O == ~($past(op1) & $past(op2)));
    endproperty
    a_nand: assert property (p_nand) else $error("complement product wrong");
    property p_skip;
        is_skip && skip_cond |=> NEXT_P_O == $past(P_I) + {12'h000, $past(INSTR_I[SKN_HI:0])} + RRE_ONE;
    endproperty
    a_skip: assert property (p_skip) else $error("skip target wrong");
    property p_sov;
        skip_ovf |=> !ovf_q;
    endproperty
    a_sov: assert property (p_sov) else $error("overflow not cleared");
    property p_spe;
        is_skip && (skc == SK_PAR) && !PARITY_ERR_I |=> !par_q && PARITY_CLR_O;
    endproperty
    a_spe: assert property (p_spe) else $error("parity not cleared");
    property p_no_pf;
        CE_I && !prot_sw && !pf_q |=> !pf_q;
    endproperty
    a_no_pf: assert property (p_no_pf) else $error("fault set while protection off");
    c_skip: cover property (is_skip && skip_cond ##1 DONE_O);
    c_illegal: cover property (illegal ##1 PF_IRQ_O);
    c_exit: cover property (is_exi && !illegal ##1 EXIT_O);
endmodule // rre_exec
`default_nettype wire

/* tb/rre_exec_tb_top.sv */
// self-checking bench for the register reference execute unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(g,e) begin checks++; if ((g)!==(e)) begin err_total++; $display("Error t=%0t got=%0h exp=%0h",$time,g,e); end end
module rre_exec_tb_top
    import rre_pkg::*;
;
    // stimulus, named as the ports so that the instance binds by name
    logic MCLK_I=0, RST_B_I=0, CE_I=1, EXEC_I=0, INSTR_PROT_I=0, INT_ENTRY_I=0, PROT_VIOL_I=0, PARITY_ERR_I=0;
    logic S_AXI_AWVALID_I=0, S_AXI_WVALID_I=0, S_AXI_BREADY_I=0, S_AXI_ARVALID_I=0, S_AXI_RREADY_I=0;
    logic [15:0] INSTR_I=0, P_I=0, A_I=0, Q_I=0, M_I=0, RET_ADDR_I=0, IRQ_REQ_I=0, IRQ_MASK_I=0;
    logic [3:0] S_AXI_AWADDR_I=0, S_AXI_WSTRB_I=4'hF, S_AXI_ARADDR_I=0;
    logic [31:0] S_AXI_WDATA_I=0;
    // observed outputs
    logic DONE_O, A_WE_O, Q_WE_O, M_WE_O, HALT_O, PROT_SET_O, PROT_CLR_O, EXIT_O, PARITY_CLR_O, PF_IRQ_O, INT_TAKE_O;
    logic S_AXI_AWREADY_O, S_AXI_WREADY_O, S_AXI_BVALID_O, S_AXI_ARREADY_O, S_AXI_RVALID_O;
    logic [15:0] NEXT_P_O, A_O, Q_O, M_O, PROT_ADDR_O;
    logic [7:0] EXIT_LEVEL_O;
    logic [1:0] S_AXI_BRESP_O, S_AXI_RRESP_O;
    logic [31:0] S_AXI_RDATA_O, d;
    logic [1:0] r;
    logic [15:0] a, q, m, p, e;
    logic [7:0] b;
    logic [3:0] n;
    int err_total=0, checks=0, cyc=0, k;
    rre_exec i_dut (.*);
    always #50 MCLK_I = ~MCLK_I;
    ////////////////////////////////////////////////////////////////////////////
    // expectations: one's complement sum with overflow in bit 16
    function automatic logic [16:0] oadd(logic [15:0] x, logic [15:0] y);
        logic [16:0] s;
        s = x + y;
        s[15:0] = s[15:0] + s[16];
        return {(x[15] == y[15]) && (s[15] != x[15]), s[15:0]};
    endfunction
    // skip condition for codes 0-7; sign tests see bit 15 only
    function automatic logic skc(logic [2:0] c, logic [15:0] x, logic [15:0] y);
        logic [15:0] t;
        t = c[2] ? y : x;
        case (c[1:0])
            0: return t == 0;
            1: return t != 0;
            2: return !t[15];
            default: return t[15];
        endcase
    endfunction
    // interregister result from operand and function bits
    function automatic logic [15:0] irx(logic [7:0] f, logic [15:0] x, logic [15:0] y, logic [15:0] z);
        logic [15:0] o1, o2;
        o1 = f[5] ? x : 16'hFFFF;
        o2 = f[4] ? (f[3] ? y | z : y) : (f[3] ? z : 16'hFFFF);
        case (f[7:6])
            0: return oadd(o1, o2);
            2: return o1 & o2;
            1: return o1 ^ o2;
            default: return ~(o1 & o2);
        endcase
    endfunction
    ////////////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        if (err_total == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // one instruction: present at an edge, taken at the next, results settle after it
    task automatic ex(input [15:0] i, pp, aa, qq, mm);
        @(posedge MCLK_I);
        INSTR_I <= i; P_I <= pp; A_I <= aa; Q_I <= qq; M_I <= mm; EXEC_I <= 1;
        IRQ_REQ_I <= $urandom; IRQ_MASK_I <= $urandom; RET_ADDR_I <= $urandom;
        @(posedge MCLK_I);
        EXEC_I <= 0;
        #1;
    endtask
    // bus write: each channel dropped at its own handshake edge
    task automatic wr(input [3:0] ad, input [31:0] dd);
        logic aw, w;
        aw = 1; w = 1;
        @(posedge MCLK_I);
        S_AXI_AWADDR_I <= ad; S_AXI_WDATA_I <= dd; S_AXI_AWVALID_I <= 1; S_AXI_WVALID_I <= 1; S_AXI_BREADY_I <= 1;
        while (aw || w) begin
            @(posedge MCLK_I);
            if (aw && S_AXI_AWREADY_O) begin aw = 0; S_AXI_AWVALID_I <= 0; end
            if (w && S_AXI_WREADY_O) begin w = 0; S_AXI_WVALID_I <= 0; end
        end
        do @(posedge MCLK_I); while (S_AXI_BVALID_O !== 1'b1);
        S_AXI_BREADY_I <= 0;
        `CHK(S_AXI_BRESP_O, RESP_OKAY)
    endtask
    task automatic rd(input [3:0] ad);
        @(posedge MCLK_I);
        S_AXI_ARADDR_I <= ad; S_AXI_ARVALID_I <= 1; S_AXI_RREADY_I <= 1;
        do @(posedge MCLK_I); while (S_AXI_ARREADY_O !== 1'b1);
        S_AXI_ARVALID_I <= 0;
        do @(posedge MCLK_I); while (S_AXI_RVALID_O !== 1'b1);
        d = S_AXI_RDATA_O; r = S_AXI_RRESP_O; S_AXI_RREADY_I <= 0;
    endtask
    // hang guard
    always @(posedge MCLK_I) begin
        cyc++;
        if (cyc == 20000) begin err_total++; end_sim(); end
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(95702));
        repeat (16) @(posedge MCLK_I);
        RST_B_I <= 1;
        wr(REG_CTRL, 32'h4); rd(REG_CTRL); `CHK(d[3:0], 4'h4)
        rd(4'h8); `CHK(r, RESP_DECERR)
        for (k = 0; k < 48; k++) begin
            a = k < 8 ? 16'h0 : k < 16 ? 16'hFFFF : $urandom; q = k < 8 ? 16'hFFFF : k < 16 ? 16'h0 : $urandom;
            p = $urandom; n = $urandom;
            e = p + (skc(k[2:0], a, q) ? {12'h0, n} + 16'h1 : 16'h1);
            ex({8'h01, 1'b0, k[2:0], n}, p, a, q, 16'h0); `CHK({DONE_O, NEXT_P_O}, {1'b1, e})
        end
        for (k = 0; k < 40; k++) begin
            b = {5'($urandom), 3'b100}; a = $urandom; q = $urandom; m = $urandom;
            ex({8'h08, b}, 16'h0, a, q, m); `CHK(A_O, irx(b, a, q, m))
        end
        for (k = 0; k < 16; k++) begin
            b = $urandom; q = $urandom;
            ex({8'h0D, b}, 16'h0, 16'h0, q, 16'h0); `CHK(Q_O, oadd(q, {{8{b[7]}}, b}) & 16'hFFFF)
        end
        ex(16'h0830, 16'h0, 16'h7FFF, 16'h0001, 16'h0); rd(REG_STAT); `CHK(d[0], 1'b1)
        ex(16'h01A2, 16'h0010, 16'h0, 16'h0, 16'h0); `CHK(NEXT_P_O, 16'h0013)
        rd(REG_STAT); `CHK(d[0], 1'b0)
        wr(REG_CTRL, 32'h3);
        ex(16'h0801, 16'h0, 16'h0, 16'h0, 16'h0); `CHK({HALT_O, M_WE_O}, 2'b10)
        rd(REG_STAT); `CHK(d[1], 1'b1)
        ex(16'h01E5, 16'h0020, 16'h0, 16'h0, 16'h0); `CHK(NEXT_P_O, 16'h0026)
        rd(REG_STAT); `CHK(d[1], 1'b0)
        // unprotected enable with protect on and fault interrupt selected, stop switch off
        wr(REG_CTRL, 32'h9);
        ex(16'h0400, 16'h0, 16'h0, 16'h0, 16'h0); `CHK({HALT_O, PF_IRQ_O}, 2'b01)
        wr(REG_CTRL, 32'h0);
        ex(16'h0600, 16'h0, 16'h0, 16'h1234, 16'h0); `CHK({PROT_SET_O, PROT_ADDR_O}, {1'b1, 16'h1234})
        ex(16'h0700, 16'h0, 16'h0, 16'h00AB, 16'h0); `CHK({PROT_CLR_O, PROT_ADDR_O}, {1'b1, 16'h00AB})
        ex(16'h0E07, 16'h0, 16'h0, 16'h0, 16'h0); `CHK({EXIT_O, EXIT_LEVEL_O, NEXT_P_O}, {1'b1, 8'h07, RET_ADDR_I})
        rd(REG_STAT); `CHK(d[3], 1'b1)
        ex(16'h0500, 16'h0, 16'h0, 16'h0, 16'h0); rd(REG_STAT); `CHK(d[3], 1'b0)
        end_sim();
    end
endmodule // rre_exec_tb_top
`default_nettype wire
